// >>> logic/stb_top.sv
// Slow time base counter with APB registers, trim and tick interrupts
`timescale 1ns/1ps

// How it works
// - Divide slow clock into eight binary taps
// - Three interrupts, each picks any tap
// - Main and RTC tap pins carry 1/2 Hz
// - Trim spans about plus/minus 488 ppm
// - RTC gets selected 1 or 2 Hz tick
// - Count register reads eight taps, rest zero
// - Any count write clears whole counter
// - Clearing may create tap falls and interrupts
// - Trim bit 12 is sign, one slows
// - Trim bits 11..0 magnitude, resets zero
// - RTC tap register is read only
// - Select register resets with interrupts disabled
// - Status register reports tick interrupts, resets zero
// - Count from zero on slow clock falls
// - Interrupt on falling edge of chosen tap
// - Codes 0..7 pick taps, 8 disables
// - Status bit set by event, write one clears
module stb_top
  import stb_pkg::*;
#(
  parameter int ACC_WIDTH = ACC_W
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output      logic [31:0]        prdata,
  output      logic               pready,
  output      logic               pslverr,
  input  wire logic               slow_clock,
  input  wire logic               rtc_clear,
  output      logic               tick_out_main,
  output      logic               tick_out_rtc,
  output      logic               rtc_tick,
  output      logic [NUM_IRQ-1:0] tick_irq,
  output      logic               irq
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Slow clock synchroniser
  // ****************************************
  logic slow_meta_q;
  logic slow_sync_q;
  logic slow_prev_q;
  wire  slow_fall = slow_prev_q & ~slow_sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end
    else
    begin
      slow_meta_q <= slow_clock;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  stb_cfg_type          cfg_q;
  stb_trim_type         trim_q;
  logic [NUM_IRQ-1:0]   stat_q;
  logic [NUM_IRQ-1:0]   stat_d;
  logic [NUM_IRQ-1:0]   mask_q;
  logic [31:0]          prdata_q;

  wire wr_en    = psel & penable & pwrite;
  wire rd_take  = psel & ~penable & ~pwrite;
  wire hit_cnt  = paddr == OFS_COUNT;
  wire hit_trim = paddr == OFS_TRIM;
  wire hit_sel  = paddr == OFS_SEL;
  wire hit_stat = paddr == OFS_STAT;
  wire hit_rtc  = paddr == OFS_RTC;
  wire hit_mask = paddr == OFS_MASK;
  wire addr_ok  = hit_cnt | hit_trim | hit_sel | hit_stat | hit_rtc | hit_mask;
  wire count_wr = wr_en & hit_cnt;
  wire [NUM_IRQ-1:0] stat_clr = (wr_en & hit_stat) ? pwdata[NUM_IRQ-1:0] : '0;

  // ****************************************
  // Trim accumulator
  // ****************************************
  logic [ACC_WIDTH-1:0] acc_q;
  wire  [ACC_WIDTH:0]   acc_sum = {1'b0, acc_q} + (ACC_WIDTH+1)'(trim_q.mag);
  wire                  carry   = acc_sum[ACC_WIDTH];
  logic [1:0]           step;

  // Carry drops a count when negative, doubles one when positive
  assign step = !slow_fall ? 2'd0 :
                !carry     ? 2'd1 :
                trim_q.sign ? 2'd0 : 2'd2;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_q <= '0;
    else if (slow_fall)
      acc_q <= acc_sum[ACC_WIDTH-1:0];
  end

  // ****************************************
  // Main and RTC counters
  // ****************************************
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    rtc_q;
  logic [NUM_TAPS-1:0] taps_prev_q;
  wire  [CNT_W-1:0]    cnt_d = count_wr ? '0 : cnt_q + CNT_W'(step);
  wire  [CNT_W-1:0]    rtc_d = rtc_clear ? '0 : rtc_q + CNT_W'(step);
  wire  [NUM_TAPS-1:0] taps     = cnt_q[TAP_LSB +: NUM_TAPS];
  wire  [NUM_TAPS-1:0] rtc_taps = rtc_q[TAP_LSB +: NUM_TAPS];
  wire  [NUM_TAPS-1:0] tap_fall = taps_prev_q & ~taps;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q       <= '0;
      rtc_q       <= '0;
      taps_prev_q <= '0;
    end
    else
    begin
      cnt_q       <= cnt_d;
      rtc_q       <= rtc_d;
      taps_prev_q <= taps;
    end
  end

  // ****************************************
  // Tick interrupts
  // ****************************************
  logic [NUM_IRQ-1:0] irq_hit;
  logic [NUM_IRQ-1:0] tick_irq_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++)
    begin : g_irq
      wire [SEL_W-1:0] code = cfg_q.sel[gi];
      // Codes above the tap range never fire
      assign irq_hit[gi] = (code < SEL_OFF) & tap_fall[code[2:0]];
    end
  endgenerate

  // Set wins over a simultaneous clear
  assign stat_d = (stat_q & ~stat_clr) | irq_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q     <= '0;
      tick_irq_q <= '0;
    end
    else
    begin
      stat_q     <= stat_d;
      tick_irq_q <= irq_hit;
    end
  end

  assign tick_irq = tick_irq_q;
  assign irq      = |(stat_q & mask_q);

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q  <= CFG_RESET;
      trim_q <= TRIM_RESET;
      mask_q <= '0;
    end
    else if (wr_en)
    begin
      if (hit_sel)
        cfg_q <= {pwdata[OUT_SEL_POS], pwdata[NUM_IRQ*SEL_W-1:0]};
      if (hit_trim)
        trim_q <= pwdata[SIGN_POS:0];
      if (hit_mask)
        mask_q <= pwdata[NUM_IRQ-1:0];
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [31:0] sel_word = 32'({cfg_q.out_2hz, 4'h0, cfg_q.sel});
  wire [31:0] rd_data  = hit_cnt  ? 32'(taps) :
                         hit_trim ? 32'(trim_q) :
                         hit_sel  ? sel_word :
                         hit_stat ? 32'(stat_q) :
                         hit_rtc  ? 32'(rtc_taps) :
                         hit_mask ? 32'(mask_q) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (rd_take)
      prdata_q <= rd_data;
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // ****************************************
  // Tick outputs
  // ****************************************
  logic main_q;
  logic rtc_out_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_q    <= 1'b0;
      rtc_out_q <= 1'b0;
    end
    else
    begin
      main_q    <= cfg_q.out_2hz ? taps[TAP_2HZ] : taps[TAP_1HZ];
      rtc_out_q <= cfg_q.out_2hz ? rtc_taps[TAP_2HZ] : rtc_taps[TAP_1HZ];
    end
  end

  assign tick_out_main = main_q;
  assign tick_out_rtc  = rtc_out_q;
  assign rtc_tick      = rtc_out_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_count_clear: assert property (count_wr |=> cnt_q == '0)
    else $error("count write did not clear counter");

  a_tap_read: assert property (rd_take && hit_cnt |=> prdata == {24'h0, $past(taps)})
    else $error("count read did not return taps");

  a_count_hold: assert property (!slow_fall && !count_wr |=> $stable(cnt_q))
    else $error("counter moved without slow clock fall");

  a_count_step: assert property (slow_fall && !carry && !count_wr
    |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("counter did not step by one");

  a_trim_drop: assert property (slow_fall && carry && trim_q.sign && !count_wr
    |=> $stable(cnt_q))
    else $error("negative trim did not drop a count");

  a_trim_add: assert property (slow_fall && carry && !trim_q.sign && !count_wr
    |=> cnt_q == $past(cnt_q) + 2'd2)
    else $error("positive trim did not add a count");

  a_stat_set: assert property (irq_hit[0] |=> stat_q[0] ##0 tick_irq[0])
    else $error("interrupt event not recorded");

  a_stat_clear: assert property (stat_clr[1] && !irq_hit[1] |=> !stat_q[1])
    else $error("write one did not clear status");

  a_sel_off: assert property (cfg_q.sel[2] == SEL_OFF |-> ##1 !tick_irq[2])
    else $error("disabled selector raised interrupt");

  a_main_out: assert property ($past(tap_fall[TAP_1HZ]) && !cfg_q.out_2hz
    && $stable(cfg_q) |-> ##1 !tick_out_main)
    else $error("main tick output not following 1 Hz tap");

  a_rtc_clear: assert property (rtc_clear |=> rtc_q == '0 ##2 !rtc_tick)
    else $error("RTC counter not cleared");

  // ****************************************
  // Register bus checks
  // ****************************************
  a_unmapped_zero: assert property (rd_take && !addr_ok |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_trim_write: assert property (wr_en && hit_trim
    |=> trim_q == $past(pwdata[SIGN_POS:0]))
    else $error("trim write not stored");

  a_trim_sign_read: assert property (rd_take && hit_trim |=> prdata[31:13] == '0)
    else $error("trim read shows reserved bits");

  a_sel_write: assert property (wr_en && hit_sel
    |=> cfg_q.sel == $past(pwdata[NUM_IRQ*SEL_W-1:0]))
    else $error("select write not stored");

  a_sel_read_zero: assert property (rd_take && hit_sel |=> prdata[15:12] == 4'h0)
    else $error("select read shows reserved bits");

  a_rtc_read: assert property (rd_take && hit_rtc |=> prdata == {24'h0, $past(rtc_taps)})
    else $error("RTC read did not return RTC taps");

  a_rtc_ro: assert property (wr_en && hit_rtc && !rtc_clear && !slow_fall
    |=> $stable(rtc_q))
    else $error("write changed RTC counter");

  a_stat_read: assert property (rd_take && hit_stat |=> prdata == {29'h0, $past(stat_q)})
    else $error("status read mismatch");

  a_mask_write: assert property (wr_en && hit_mask
    |=> mask_q == $past(pwdata[NUM_IRQ-1:0]))
    else $error("mask write not stored");

  a_pslverr_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error flagged outside access phase");

  // ****************************************
  // Counter and interrupt checks
  // ****************************************
  a_rtc_step: assert property (slow_fall && !carry && !rtc_clear
    |=> rtc_q == $past(rtc_q) + 1'b1)
    else $error("RTC counter did not step by one");

  a_acc_hold: assert property (!slow_fall |=> $stable(acc_q))
    else $error("trim accumulator moved without slow fall");

  a_fall_single: assert property (slow_fall |=> !slow_fall)
    else $error("one slow clock fall counted twice");

  a_rtc_source: assert property ($past(cfg_q.out_2hz) && $past(rtc_taps[TAP_2HZ])
    |-> rtc_tick)
    else $error("RTC tick not following 2 Hz tap");

  a_main_2hz: assert property ($past(cfg_q.out_2hz) && $past(taps[TAP_2HZ])
    |-> tick_out_main)
    else $error("main tick output not following 2 Hz tap");

  a_irq_pulse: assert property (tick_irq[1] |=> !tick_irq[1])
    else $error("tick interrupt longer than one cycle");

  a_tap_irq: assert property (tap_fall[TAP_1HZ] && cfg_q.sel[1] == 4'h7
    |=> tick_irq[1])
    else $error("1 Hz tap fall raised no interrupt");

  a_irq_level: assert property (tick_irq[0] && mask_q[0] |-> irq)
    else $error("unmasked event did not raise irq");

  a_stat_hold: assert property (!(|irq_hit) && !(|stat_clr) |=> $stable(stat_q))
    else $error("status changed without event or clear");

  a_bad_code: assert property (cfg_q.sel[0] > SEL_OFF |=> !tick_irq[0])
    else $error("prohibited selector raised interrupt");

  a_clear_irq: assert property (count_wr && taps[0] && cfg_q.sel[2] == 4'h0
    |=> ##1 tick_irq[2])
    else $error("counter clear did not raise tap interrupt");

  c_irq_fire: cover property (irq_hit[0] ##1 irq);
  c_trim_carry: cover property (slow_fall && carry);
  c_clear_fall: cover property (count_wr ##1 |tap_fall);
  c_set_clear: cover property (|(stat_clr & irq_hit));
  c_rtc_clear: cover property (rtc_clear ##1 !rtc_tick);

endmodule

// >>> logic/stb_pkg.sv
// Constants and types shared by the slow time base counter
package stb_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_TRIM  = 8'h04;
  localparam logic [7:0] OFS_SEL   = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;
  localparam logic [7:0] OFS_RTC   = 8'h10;
  localparam logic [7:0] OFS_MASK  = 8'h14;

  // ****************************************
  // Sizes and field positions
  // ****************************************
  localparam int NUM_TAPS    = 8;
  localparam int NUM_IRQ     = 3;
  localparam int CNT_W       = 15;
  localparam int TAP_LSB     = 7;
  localparam int TAP_2HZ     = 6;
  localparam int TAP_1HZ     = 7;
  localparam int SEL_W       = 4;
  localparam int MAG_W       = 12;
  localparam int SIGN_POS    = 12;
  localparam int OUT_SEL_POS = 16;
  localparam int ACC_W       = 23;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [SEL_W-1:0] SEL_OFF = 4'h8;

  typedef struct packed {
    logic                            out_2hz;
    logic [NUM_IRQ-1:0][SEL_W-1:0]   sel;
  } stb_cfg_type;

  typedef struct packed {
    logic             sign;
    logic [MAG_W-1:0] mag;
  } stb_trim_type;

  localparam stb_cfg_type  CFG_RESET  = 13'h0888;
  localparam stb_trim_type TRIM_RESET = 13'h0000;

endpackage

// >>> testbench/stb_tick_env.sv
// Slow clock source and RTC-side tick consumer for the time base
`timescale 1ns/1ps
module stb_tick_env #(
  parameter int HALF = 3
)(
  input  wire logic pclk,
  input  wire logic rtc_tick,
  output      logic slow_clock,
  output      logic rtc_clear
);
  int rises;

  initial
  begin
    slow_clock = 1'b1;
    rtc_clear  = 1'b0;
    rises      = 0;
  end

  always @(posedge rtc_tick) rises++;

  // ****************************************
  // Bursts of slow clock falls
  // ****************************************
  // Clock stands still between bursts so counts stay exact
  task automatic run(input int n);
    repeat (n)
    begin
      repeat (HALF) @(posedge pclk);
      slow_clock <= 1'b0;
      repeat (HALF) @(posedge pclk);
      slow_clock <= 1'b1;
    end
    repeat (8) @(posedge pclk);
  endtask

  task automatic clr();
    @(posedge pclk);
    rtc_clear <= 1'b1;
    @(posedge pclk);
    rtc_clear <= 1'b0;
  endtask
endmodule

// >>> testbench/tb_stb_top.sv
// Self-checking bench for the slow time base counter
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_stb_top;
  import stb_pkg::*;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready, pslverr, slow_clock, rtc_clear;
  logic               tick_out_main, tick_out_rtc, rtc_tick, irq;
  logic [NUM_IRQ-1:0] tick_irq;
  int                 error_cnt = 0, checks = 0, cyc = 0, pulses = 0;

  always #2 pclk = ~pclk;

  stb_top #(.ACC_WIDTH(4)) u_stb_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_clock(slow_clock), .rtc_clear(rtc_clear),
    .tick_out_main(tick_out_main), .tick_out_rtc(tick_out_rtc), .rtc_tick(rtc_tick),
    .tick_irq(tick_irq), .irq(irq));

  stb_tick_env u_stb_tick_env (.pclk(pclk), .rtc_tick(rtc_tick), .slow_clock(slow_clock),
    .rtc_clear(rtc_clear));

  always @(posedge pclk)
  begin
    cyc++;
    if (tick_irq[0] === 1'b1)
      pulses++;
    if (cyc == 100000)
    begin
      error_cnt++;
      results();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] taps(input int n);
    return 32'((n >> 7) & 8'hFF);
  endfunction

  function automatic int trimmed(input int n, input int sg);
    return sg ? n - n / 2 : n + n / 2;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK("read data", x, q)
    `CHK("slave error", 1'b0, e)
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [31:0] d, s, q;
    logic        er;
    int          k;
    void'($urandom(32'h4862));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc(OFS_COUNT, 32'h0);
    rc(OFS_TRIM, 32'h0);
    rc(OFS_SEL, 32'h0000_0888);
    rc(OFS_STAT, 32'h0);
    rc(OFS_RTC, 32'h0);
    d = $urandom();
    wr(OFS_TRIM, d);
    rc(OFS_TRIM, d & 32'h0000_1FFF);
    s = {15'h0, d[16], 4'h0, 4'($urandom_range(0, 8)), 4'($urandom_range(0, 8)),
         4'($urandom_range(0, 8))};
    wr(OFS_SEL, s | (d & 32'hFFFE_F000));
    rc(OFS_SEL, s);
    wr(OFS_RTC, d);
    rc(OFS_RTC, 32'h0);
    wr(8'h18, d);
    apb(1'b0, 8'h18, 32'h0, q, er);
    `CHK("unmapped data", 32'h0, q)
    `CHK("unmapped error", 1'b1, er)
    wr(OFS_TRIM, 32'h0);
    wr(OFS_SEL, 32'h0000_0888);
    wr(OFS_MASK, 32'h1);
    k = $urandom_range(128, 1000);
    u_stb_tick_env.run(k);
    rc(OFS_COUNT, taps(k));
    rc(OFS_RTC, taps(k));
    for (int c = 0; c < 3; c++)
    begin
      wr(OFS_SEL, 32'h0000_0888);
      wr(OFS_COUNT, $urandom());
      wr(OFS_STAT, 32'h7);
      wr(OFS_SEL, 32'h0000_0800 | ((c + 1) << 4) | c);
      pulses = 0;
      u_stb_tick_env.run(1 << (8 + c));
      rc(OFS_COUNT, taps(1 << (8 + c)));
      rc(OFS_STAT, 32'h1);
      `CHK("irq pulses", 1, pulses)
      `CHK("irq level", 1'b1, irq)
      wr(OFS_STAT, 32'h1);
      rc(OFS_STAT, 32'h0);
      `CHK("irq idle", 1'b0, irq)
    end
    wr(OFS_SEL, 32'h0000_0880);
    u_stb_tick_env.run(128);
    wr(OFS_STAT, 32'h7);
    wr(OFS_COUNT, 32'h0);
    rc(OFS_STAT, 32'h1);
    wr(OFS_SEL, 32'h0000_0888);
    for (int sg = 0; sg < 2; sg++)
    begin
      wr(OFS_TRIM, (sg << 12) | 8);
      wr(OFS_COUNT, 32'h0);
      u_stb_tick_env.run(200);
      rc(OFS_COUNT, taps(trimmed(200, sg)));
    end
    wr(OFS_TRIM, 32'h0);
    wr(OFS_SEL, 32'h0001_0888);
    wr(OFS_COUNT, 32'h0);
    u_stb_tick_env.clr();
    k = u_stb_tick_env.rises;
    u_stb_tick_env.run(8192);
    `CHK("main pin", 1'b1, tick_out_main)
    `CHK("rtc pin", 1'b1, tick_out_rtc)
    `CHK("rtc tick rises", k + 1, u_stb_tick_env.rises)
    wr(OFS_SEL, 32'h0000_0888);
    repeat (4) @(posedge pclk);
    `CHK("main pin slow", 1'b0, tick_out_main)
    results();
  end
endmodule
